// ===== hdl/port_mux_pkg.sv
package port_mux_pkg;

	// Register byte offsets on the bus
	localparam logic [7:0] OFS_MCU_CONTROL = 8'h00;
	localparam logic [7:0] OFS_PORT_A_DIR  = 8'h04;
	localparam logic [7:0] OFS_PORT_A_OUT  = 8'h08;
	localparam logic [7:0] OFS_PORT_A_PIN  = 8'h0C;
	localparam logic [7:0] OFS_PORT_B_DIR  = 8'h10;
	localparam logic [7:0] OFS_PORT_B_OUT  = 8'h14;
	localparam logic [7:0] OFS_PORT_B_PIN  = 8'h18;
	localparam logic [7:0] OFS_PULLUP_STAT = 8'h1C;

	// Control register field positions
	localparam int BIT_DEBUG_PORT_DISABLE  = 7;
	localparam int BIT_GLOBAL_PULLUP_DIS   = 4;
	localparam int BIT_VECTOR_TABLE_SELECT = 1;
	localparam int BIT_VECTOR_CHANGE_EN    = 0;

	// Writable bits of the control register; the rest read zero
	localparam logic [7:0] MCU_CONTROL_WMASK = 8'h93;

	// Reset values
	localparam logic [7:0] RST_MCU_CONTROL = 8'h00;
	localparam logic [7:0] RST_PORT_DIR    = 8'h00;
	localparam logic [7:0] RST_PORT_OUT    = 8'h00;

	// Bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Synchroniser depth for pad inputs
	localparam int SYNC_STAGES = 2;

endpackage

// ===== hdl/pad_sync.sv
`timescale 1ns/1ns
// Two-flop synchroniser for a group of pad inputs
module pad_sync #(
	parameter int WIDTH = 8
) (
	input  wire logic             aclk,     // System clock
	input  wire logic             aresetn,  // Synchronous reset, active low
	input  wire logic [WIDTH-1:0] pad_in,   // Asynchronous pad levels
	output logic      [WIDTH-1:0] sync_out  // Levels safe to use
);

	logic [WIDTH-1:0] meta;                 // First stage, read by second only

	// First stage catches the raw pad
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta <= '0;
		end else begin
			meta <= pad_in;
		end
	end

	// Second stage settles metastability
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync_out <= '0;
		end else begin
			sync_out <= meta;
		end
	end

endmodule

// ===== hdl/pin_override_cell.sv
`timescale 1ns/1ns
// Generic override cell for one pad: peripheral overrides win over port bits
module pin_override_cell (
	input  wire logic pin_direction_bit,      // Port direction bit
	input  wire logic pin_output_bit,         // Port output bit
	input  wire logic global_pullup_disable,  // Shared pull-up kill
	input  wire logic pullup_override_en,     // Peripheral owns pull-up
	input  wire logic pullup_override_val,    // Pull-up value when owned
	input  wire logic direction_override_en,  // Peripheral owns direction
	input  wire logic direction_override_val, // Direction when owned
	input  wire logic value_override_en,      // Peripheral owns value
	input  wire logic value_override_val,     // Value when owned
	output logic      drive_en,               // Output driver enable
	output logic      drive_val,              // Driven level
	output logic      pullup_en               // Pull-up enable
);

	// Direction falls back to the port bit when not overridden
	assign drive_en = direction_override_en ? direction_override_val
		: pin_direction_bit;

	// Value falls back to the port bit when not overridden
	assign drive_val = value_override_en ? value_override_val
		: pin_output_bit;

	// Default pull-up: input, bit high, pull-ups allowed
	assign pullup_en = pullup_override_en ? pullup_override_val
		: (!pin_direction_bit && pin_output_bit && !global_pullup_disable);

endmodule

// ===== hdl/port_ab_alternate_function_mux.sv
`timescale 1ns/1ns
// Pin mux for ports A and B with an AXI4-Lite register slave
module port_ab_alternate_function_mux (
	input  wire logic       aclk,                // System clock, 50 MHz
	input  wire logic       aresetn,             // Synchronous reset, active low
	// AXI4-Lite slave
	input  wire logic [7:0] awaddr,              // Write address
	input  wire logic       awvalid,             // Write address valid
	output logic            awready,             // Write address ready
	input  wire logic [31:0] wdata,              // Write data
	input  wire logic [3:0] wstrb,               // Write strobes
	input  wire logic       wvalid,              // Write data valid
	output logic            wready,              // Write data ready
	output logic [1:0]      bresp,               // Write response
	output logic            bvalid,              // Write response valid
	input  wire logic       bready,              // Write response ready
	input  wire logic [7:0] araddr,              // Read address
	input  wire logic       arvalid,             // Read address valid
	output logic            arready,             // Read address ready
	output logic [31:0]     rdata,               // Read data
	output logic [1:0]      rresp,               // Read response
	output logic            rvalid,              // Read data valid
	input  wire logic       rready,              // Read data ready
	// External memory interface
	input  wire logic       ext_mem_enable,      // Interface owns port A
	input  wire logic       xmem_addr_phase,     // Address being driven
	input  wire logic       xmem_write_strobe,   // Write strobe active
	input  wire logic [7:0] xmem_addr_lo,        // Low address byte
	input  wire logic [7:0] xmem_wdata,          // Write data byte
	output logic [7:0]      xmem_rdata,          // Data read from pads
	output logic            address_phase_active,// Address on the bus
	// Timer compare outputs
	input  wire logic       timer0_cmp_a_en,     // Timer 0 A owns PB7
	input  wire logic       timer0_cmp_a_out,    // Timer 0 A waveform
	input  wire logic       timer1_cmp_c_en,     // Timer 1 C owns PB7
	input  wire logic       timer1_cmp_c_out,    // Timer 1 C waveform
	input  wire logic       timer1_cmp_b_en,     // Timer 1 B owns PB6
	input  wire logic       timer1_cmp_b_out,    // Timer 1 B waveform
	input  wire logic       timer1_cmp_a_en,     // Timer 1 A owns PB5
	input  wire logic       timer1_cmp_a_out,    // Timer 1 A waveform
	input  wire logic       timer2_cmp_a_en,     // Timer 2 A owns PB4
	input  wire logic       timer2_cmp_a_out,    // Timer 2 A waveform
	// SPI
	input  wire logic       spi_enable_bit,      // SPI enabled
	input  wire logic       spi_master_select,   // SPI is master
	input  wire logic       spi_slave_out,       // Slave data to MISO
	input  wire logic       spi_master_out,      // Master data to MOSI
	input  wire logic       spi_sck_out,         // Master clock to SCK
	output logic            spi_master_in,       // MISO level
	output logic            spi_slave_in,        // MOSI level
	output logic            spi_sck_in,          // SCK level
	output logic            spi_select_in,       // SS level
	// Pads
	input  wire logic [7:0] port_a_pad_in,       // Port A pad levels
	output logic [7:0]      port_a_pad_out,      // Port A driven levels
	output logic [7:0]      port_a_pad_oe,       // Port A driver enables
	output logic [7:0]      port_a_pullup,       // Port A pull-up enables
	input  wire logic [7:0] port_b_pad_in,       // Port B pad levels
	output logic [7:0]      port_b_pad_out,      // Port B driven levels
	output logic [7:0]      port_b_pad_oe,       // Port B driver enables
	output logic [7:0]      port_b_pullup,       // Port B pull-up enables
	output logic            debug_port_disable,  // Control bit 7
	output logic            vector_table_select, // Control bit 1
	output logic            vector_change_enable // Control bit 0
);

	////////////////////////////////////////////////////////////////////////
	// Register state

	logic [7:0] mcu_control;       // Control register
	logic [7:0] port_a_dir;        // Port A direction bits
	logic [7:0] port_a_out;        // Port A output bits
	logic [7:0] port_b_dir;        // Port B direction bits
	logic [7:0] port_b_out;        // Port B output bits
	logic [7:0] port_a_sync;       // Port A pads after synchroniser
	logic [7:0] port_b_sync;       // Port B pads after synchroniser
	logic       global_pullup_disable; // Shared pull-up kill

	assign global_pullup_disable = mcu_control[port_mux_pkg::BIT_GLOBAL_PULLUP_DIS];

	////////////////////////////////////////////////////////////////////////
	// Bus slave: write side holds address and data until both are in

	logic       aw_held;           // Write address captured
	logic       w_held;            // Write data captured
	logic [7:0] aw_addr_q;         // Captured write address
	logic [7:0] w_data_q;          // Captured low data byte
	logic       w_lane0_q;         // Low byte lane enabled
	logic       do_write;          // Both halves present, commit now
	logic       wr_hit;            // Write address is mapped

	assign do_write = aw_held && w_held && !bvalid;

	// Address ready drops once taken, returns after the response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'h0;
		end else begin
			awready <= !(awvalid && awready) && !aw_held && !bvalid;
		end
	end

	// Data ready follows the same pattern
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wready <= 1'h0;
		end else begin
			wready <= !(wvalid && wready) && !w_held && !bvalid;
		end
	end

	// Capture the write address, in either order with data
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held   <= 1'h0;
			aw_addr_q <= 8'h00;
		end else if (awvalid && awready) begin
			aw_held   <= 1'h1;
			aw_addr_q <= awaddr;
		end else if (do_write) begin
			aw_held   <= 1'h0;
		end
	end

	// Capture the write data; only the low lane carries register bits
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held    <= 1'h0;
			w_data_q  <= 8'h00;
			w_lane0_q <= 1'h0;
		end else if (wvalid && wready) begin
			w_held    <= 1'h1;
			w_data_q  <= wdata[7:0];
			w_lane0_q <= wstrb[0];
		end else if (do_write) begin
			w_held    <= 1'h0;
		end
	end

	// Decode of the captured write address
	always_comb begin
		unique case ({aw_addr_q[7:2], 2'h0})
			port_mux_pkg::OFS_MCU_CONTROL,
			port_mux_pkg::OFS_PORT_A_DIR,
			port_mux_pkg::OFS_PORT_A_OUT,
			port_mux_pkg::OFS_PORT_A_PIN,
			port_mux_pkg::OFS_PORT_B_DIR,
			port_mux_pkg::OFS_PORT_B_OUT,
			port_mux_pkg::OFS_PORT_B_PIN,
			port_mux_pkg::OFS_PULLUP_STAT: wr_hit = 1'h1;
			default:                       wr_hit = 1'h0;
		endcase
	end

	// Response one cycle after both halves are held
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'h0;
			bresp  <= port_mux_pkg::RESP_OKAY;
		end else if (do_write) begin
			bvalid <= 1'h1;
			bresp  <= wr_hit ? port_mux_pkg::RESP_OKAY : port_mux_pkg::RESP_SLVERR;
		end else if (bvalid && bready) begin
			bvalid <= 1'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Writable registers; read-only ones silently ignore writes

	logic wr_en;                   // Commit with low lane enabled
	assign wr_en = do_write && w_lane0_q;

	// Control register: reserved bits stay zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mcu_control <= port_mux_pkg::RST_MCU_CONTROL;
		end else if (wr_en && aw_addr_q[7:2] == port_mux_pkg::OFS_MCU_CONTROL[7:2]) begin
			mcu_control <= w_data_q & port_mux_pkg::MCU_CONTROL_WMASK;
		end
	end

	// Port A direction and output bits
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			port_a_dir <= port_mux_pkg::RST_PORT_DIR;
			port_a_out <= port_mux_pkg::RST_PORT_OUT;
		end else if (wr_en) begin
			if (aw_addr_q[7:2] == port_mux_pkg::OFS_PORT_A_DIR[7:2]) begin
				port_a_dir <= w_data_q;
			end
			if (aw_addr_q[7:2] == port_mux_pkg::OFS_PORT_A_OUT[7:2]) begin
				port_a_out <= w_data_q;
			end
		end
	end

	// Port B direction and output bits
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			port_b_dir <= port_mux_pkg::RST_PORT_DIR;
			port_b_out <= port_mux_pkg::RST_PORT_OUT;
		end else if (wr_en) begin
			if (aw_addr_q[7:2] == port_mux_pkg::OFS_PORT_B_DIR[7:2]) begin
				port_b_dir <= w_data_q;
			end
			if (aw_addr_q[7:2] == port_mux_pkg::OFS_PORT_B_OUT[7:2]) begin
				port_b_out <= w_data_q;
			end
		end
	end

	// Control bits that leave the block
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			debug_port_disable   <= 1'h0;
			vector_table_select  <= 1'h0;
			vector_change_enable <= 1'h0;
		end else begin
			debug_port_disable   <= mcu_control[port_mux_pkg::BIT_DEBUG_PORT_DISABLE];
			vector_table_select  <= mcu_control[port_mux_pkg::BIT_VECTOR_TABLE_SELECT];
			vector_change_enable <= mcu_control[port_mux_pkg::BIT_VECTOR_CHANGE_EN];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bus slave: read side answers on the edge after the address

	logic [31:0] next_rdata;       // Read mux result
	logic        rd_hit;           // Read address is mapped

	// Read mux; status shows the pull-ups actually applied
	always_comb begin
		next_rdata = 32'h0000_0000;
		rd_hit     = 1'h1;
		unique case ({araddr[7:2], 2'h0})
			port_mux_pkg::OFS_MCU_CONTROL: next_rdata[7:0]  = mcu_control;
			port_mux_pkg::OFS_PORT_A_DIR:  next_rdata[7:0]  = port_a_dir;
			port_mux_pkg::OFS_PORT_A_OUT:  next_rdata[7:0]  = port_a_out;
			port_mux_pkg::OFS_PORT_A_PIN:  next_rdata[7:0]  = port_a_sync;
			port_mux_pkg::OFS_PORT_B_DIR:  next_rdata[7:0]  = port_b_dir;
			port_mux_pkg::OFS_PORT_B_OUT:  next_rdata[7:0]  = port_b_out;
			port_mux_pkg::OFS_PORT_B_PIN:  next_rdata[7:0]  = port_b_sync;
			port_mux_pkg::OFS_PULLUP_STAT: next_rdata[15:0] = {port_b_pullup, port_a_pullup};
			default:                       rd_hit           = 1'h0;
		endcase
	end

	// Address ready drops while a read answer is pending
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'h0;
		end else begin
			arready <= !(arvalid && arready) && !rvalid;
		end
	end

	// Read data and response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'h0;
			rdata  <= 32'h0000_0000;
			rresp  <= port_mux_pkg::RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'h1;
			rdata  <= next_rdata;
			rresp  <= rd_hit ? port_mux_pkg::RESP_OKAY : port_mux_pkg::RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid <= 1'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pad input synchronisers

	pad_sync #(.WIDTH(8)) u_sync_a (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.pad_in   (port_a_pad_in),
		.sync_out (port_a_sync)
	);

	pad_sync #(.WIDTH(8)) u_sync_b (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.pad_in   (port_b_pad_in),
		.sync_out (port_b_sync)
	);

	////////////////////////////////////////////////////////////////////////
	// Port A overrides from the external memory interface

	logic       xmem_drive;        // Address or write phase
	logic [7:0] pa_pullup_override_en;           // Pull-up override enables
	logic [7:0] pa_direction_override_val;           // Direction override values
	logic [7:0] pa_value_override_val;           // Value override values

	assign xmem_drive = xmem_addr_phase || xmem_write_strobe;
	// Idle bus: pull-ups forced off so the pads float to the bus
	assign pa_pullup_override_en = {8{ext_mem_enable && !xmem_drive}};
	assign pa_direction_override_val = {8{xmem_drive}};
	assign pa_value_override_val = (xmem_addr_lo & {8{xmem_addr_phase}})
		| (xmem_wdata & {8{xmem_write_strobe}});

	////////////////////////////////////////////////////////////////////////
	// Port B overrides from timers and SPI

	logic       spi_as_master;     // SPI enabled as master
	logic       spi_as_slave;      // SPI enabled as slave
	logic [7:0] pb_pullup_override_en;           // Pull-up override enables
	logic [7:0] pb_value_override_en;           // Value override enables
	logic [7:0] pb_value_override_val;           // Value override values

	assign spi_as_master = spi_enable_bit && spi_master_select;
	assign spi_as_slave  = spi_enable_bit && !spi_master_select;

	// Forced inputs: MISO as master, the other three as slave
	assign pb_pullup_override_en = {4'h0, spi_as_master, {3{spi_as_slave}}};

	// Timer outputs need the direction bit, so only value is overridden
	assign pb_value_override_en = {timer0_cmp_a_en || timer1_cmp_c_en,
		timer1_cmp_b_en,
		timer1_cmp_a_en,
		timer2_cmp_a_en,
		spi_as_slave, spi_as_master, spi_as_master, 1'h0};

	// Both PB7 sources enabled merge by OR
	assign pb_value_override_val = {(timer0_cmp_a_en && timer0_cmp_a_out)
			|| (timer1_cmp_c_en && timer1_cmp_c_out),
		timer1_cmp_b_out,
		timer1_cmp_a_out,
		timer2_cmp_a_out,
		spi_slave_out, spi_master_out, spi_sck_out, 1'h0};

	////////////////////////////////////////////////////////////////////////
	// Per-pin override cells

	logic [7:0] pa_oe;             // Port A driver enable
	logic [7:0] pa_val;            // Port A driven level
	logic [7:0] pa_pu;             // Port A pull-up
	logic [7:0] pb_oe;             // Port B driver enable
	logic [7:0] pb_val;            // Port B driven level
	logic [7:0] pb_pu;             // Port B pull-up

	// One cell per pin of each port
	for (genvar i = 0; i < 8; i++) begin : g_pin
		pin_override_cell u_cell_a (
			.pin_direction_bit      (port_a_dir[i]),
			.pin_output_bit         (port_a_out[i]),
			.global_pullup_disable  (global_pullup_disable),
			.pullup_override_en     (pa_pullup_override_en[i]),
			.pullup_override_val    (1'h0),
			.direction_override_en  (ext_mem_enable),
			.direction_override_val (pa_direction_override_val[i]),
			.value_override_en      (ext_mem_enable),
			.value_override_val     (pa_value_override_val[i]),
			.drive_en               (pa_oe[i]),
			.drive_val              (pa_val[i]),
			.pullup_en              (pa_pu[i])
		);

		// Forced SPI inputs keep port-bit pull-up control
		pin_override_cell u_cell_b (
			.pin_direction_bit      (port_b_dir[i]),
			.pin_output_bit         (port_b_out[i]),
			.global_pullup_disable  (global_pullup_disable),
			.pullup_override_en     (pb_pullup_override_en[i]),
			.pullup_override_val    (port_b_out[i] && !global_pullup_disable),
			.direction_override_en  (pb_pullup_override_en[i]),
			.direction_override_val (1'h0),
			.value_override_en      (pb_value_override_en[i]),
			.value_override_val     (pb_value_override_val[i]),
			.drive_en               (pb_oe[i]),
			.drive_val              (pb_val[i]),
			.pullup_en              (pb_pu[i])
		);
	end

	////////////////////////////////////////////////////////////////////////
	// Registered pad controls; pull-ups released while a pin drives, except port A pins driven by the memory interface

	// Port A pad registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			port_a_pad_oe  <= 8'h00;
			port_a_pad_out <= 8'h00;
			port_a_pullup  <= 8'h00;
		end else begin
			port_a_pad_oe  <= pa_oe;
			port_a_pad_out <= pa_val;
			port_a_pullup  <= pa_pu;
		end
	end

	// Port B pad registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			port_b_pad_oe  <= 8'h00;
			port_b_pad_out <= 8'h00;
			port_b_pullup  <= 8'h00;
		end else begin
			port_b_pad_oe  <= pb_oe;
			port_b_pad_out <= pb_val;
			port_b_pullup  <= pb_pu;
		end
	end

	// Address-phase flag exists only while the interface owns port A
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			address_phase_active <= 1'h0;
		end else begin
			address_phase_active <= ext_mem_enable && xmem_addr_phase;
		end
	end

	// Pad levels handed to the peripherals
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			xmem_rdata    <= 8'h00;
			spi_master_in <= 1'h0;
			spi_slave_in  <= 1'h0;
			spi_sck_in    <= 1'h0;
			spi_select_in <= 1'h0;
		end else begin
			xmem_rdata    <= port_a_sync;
			spi_master_in <= port_b_sync[3];
			spi_slave_in  <= port_b_sync[2];
			spi_sck_in    <= port_b_sync[1];
			spi_select_in <= port_b_sync[0];
		end
	end

endmodule

// ===== sim/pad_partner.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////
// Pads of one port: block driver wins, then far side, then pull-up
module pad_partner (
	input  wire logic       aclk,   // Clock for the float pattern
	input  wire logic [7:0] drv,    // Levels the block drives
	input  wire logic [7:0] oe,     // Block driver enables
	input  wire logic [7:0] pull,   // Pull-up enables
	input  wire logic [7:0] ext,    // Far side levels
	input  wire logic [7:0] ext_en, // Far side drives
	output logic      [7:0] pad     // Resolved level
);
	logic [7:0] flt = 8'hA5; // Undriven pins wander so no stale value passes
	always @(posedge aclk) flt <= ~flt;
	assign pad = oe & drv | ~oe & ext_en & ext | ~oe & ~ext_en & (pull | flt);
endmodule

// ===== sim/port_mux_monitor.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////
// Override checks seen from the mux ports
module port_mux_monitor (
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic       ext_mem_enable,
	input wire logic       xmem_addr_phase,
	input wire logic       xmem_write_strobe,
	input wire logic [7:0] xmem_addr_lo,
	input wire logic [7:0] xmem_wdata,
	input wire logic [7:0] xmem_rdata,
	input wire logic [7:0] port_a_pad_in,
	input wire logic       address_phase_active,
	input wire logic       timer0_cmp_a_en,
	input wire logic       timer0_cmp_a_out,
	input wire logic       timer1_cmp_c_en,
	input wire logic       timer1_cmp_c_out,
	input wire logic       spi_enable_bit,
	input wire logic       spi_master_select,
	input wire logic [7:0] port_a_pad_out,
	input wire logic [7:0] port_a_pad_oe,
	input wire logic [7:0] port_a_pullup,
	input wire logic [7:0] port_b_pad_out,
	input wire logic [7:0] port_b_pad_oe
);
	logic [2:0] up;        // Cycles since reset, so stale history is skipped
	wire        ok = up[2]; // History valid
	always_ff @(posedge aclk) begin
		if (!aresetn) up <= 3'h0;
		else if (!ok) up <= up + 3'h1;
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Memory interface phases
	sequence s_adr; ok && ext_mem_enable && xmem_addr_phase && !xmem_write_strobe; endsequence
	sequence s_wr; ok && ext_mem_enable && xmem_write_strobe && !xmem_addr_phase; endsequence
	sequence s_idle; ok && ext_mem_enable && !xmem_addr_phase && !xmem_write_strobe; endsequence
	chk_ada_tracks: assert property (ok |=> address_phase_active ==
		$past(ext_mem_enable && xmem_addr_phase)) else $error("address flag wrong");
	chk_a_direction: assert property (ok && ext_mem_enable |=> port_a_pad_oe ==
		{8{$past(xmem_addr_phase || xmem_write_strobe)}}) else $error("port A direction wrong");
	chk_a_address: assert property (s_adr |=> port_a_pad_out == $past(xmem_addr_lo))
		else $error("port A address wrong");
	chk_a_wdata: assert property (s_wr |=> port_a_pad_out == $past(xmem_wdata))
		else $error("port A write data wrong");
	chk_a_pullup_off: assert property (s_idle |=> port_a_pullup == 8'h00)
		else $error("port A pull-up not off");
	chk_b7_timer0: assert property (ok && timer0_cmp_a_en && !timer1_cmp_c_en ##1
		port_b_pad_oe[7] |-> port_b_pad_out[7] == $past(timer0_cmp_a_out))
		else $error("pin B7 timer wrong");
	chk_b7_both: assert property (ok && timer0_cmp_a_en && timer1_cmp_c_en ##1
		port_b_pad_oe[7] |-> port_b_pad_out[7] == $past(timer0_cmp_a_out | timer1_cmp_c_out))
		else $error("pin B7 merge wrong");
	chk_miso_input: assert property (ok && spi_enable_bit && spi_master_select |=>
		!port_b_pad_oe[3]) else $error("master input driven");
	chk_pad_read: assert property (ok |-> xmem_rdata == $past(port_a_pad_in, 3))
		else $error("pad read wrong");
endmodule
bind port_ab_alternate_function_mux port_mux_monitor u_port_mux_monitor (.*);

// ===== sim/tb.sv
`timescale 1ns/1ns
module tb;
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid;
	logic        arready, rvalid, rready, ext_mem_enable, xmem_addr_phase, xmem_write_strobe;
	logic        address_phase_active, spi_enable_bit, spi_master_select, spi_slave_out;
	logic        spi_master_out, spi_sck_out, spi_master_in, spi_slave_in, spi_sck_in;
	logic        spi_select_in, debug_port_disable, vector_table_select, vector_change_enable;
	logic        timer0_cmp_a_en, timer0_cmp_a_out, timer1_cmp_c_en, timer1_cmp_c_out;
	logic        timer1_cmp_b_en, timer1_cmp_b_out, timer1_cmp_a_en, timer1_cmp_a_out;
	logic        timer2_cmp_a_en, timer2_cmp_a_out;
	logic [1:0]  bresp, rresp;
	logic [3:0]  wstrb;
	logic [7:0]  awaddr, araddr, xmem_addr_lo, xmem_wdata, xmem_rdata, a_ext, a_ext_en, b_ext;
	logic [7:0]  port_a_pad_in, port_a_pad_out, port_a_pad_oe, port_a_pullup;
	logic [7:0]  port_b_pad_in, port_b_pad_out, port_b_pad_oe, port_b_pullup;
	logic [7:0]  da, oa, db, ob, v, dv, pb; // Settings and expected pin levels
	logic [31:0] wdata, rdata, r;
	logic [2:0]  mem;                        // Memory enable, address, write
	logic [9:0]  tmr, t;                     // Timer enables and waveforms
	logic [4:0]  spi, s;                     // SPI enable, master, data, clock
	logic [33:0] exp_q[$], got, want;        // Noted {resp, data}
	int          compares, miscompares;
	assign {ext_mem_enable, xmem_addr_phase, xmem_write_strobe} = mem;
	assign {timer0_cmp_a_en, timer0_cmp_a_out, timer1_cmp_c_en, timer1_cmp_c_out, timer1_cmp_b_en,
		timer1_cmp_b_out, timer1_cmp_a_en, timer1_cmp_a_out, timer2_cmp_a_en, timer2_cmp_a_out} = tmr;
	assign {spi_enable_bit, spi_master_select, spi_slave_out, spi_master_out, spi_sck_out} = spi;
	port_ab_alternate_function_mux u_port_ab_alternate_function_mux (.*);
	pad_partner u_pad_a (.aclk(aclk), .drv(port_a_pad_out), .oe(port_a_pad_oe),
		.pull(port_a_pullup), .ext(a_ext), .ext_en(a_ext_en), .pad(port_a_pad_in));
	pad_partner u_pad_b (.aclk(aclk), .drv(port_b_pad_out), .oe(port_b_pad_oe),
		.pull(port_b_pullup), .ext(b_ext), .ext_en(8'hFF), .pad(port_b_pad_in));
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end
	task automatic final_report;
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// Bus write; releases the address and data channels once taken, bready stays high
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] e = 2'h0);
		exp_q.push_back({e, 32'h0});
		awaddr <= a;
		wdata <= {24'h0, d};
		{awvalid, wvalid, bready} <= 3'h7;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
	endtask
	// Bus read of one register
	task automatic rd(input logic [7:0] a, input logic [15:0] d);
		exp_q.push_back({18'h0, d});
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
	endtask
	// Each bus answer against the oldest note
	always @(posedge aclk) begin
		if (bvalid && bready || rvalid && rready) begin
			got = bvalid ? {bresp, 32'h0} : {rresp, rdata};
			want = exp_q.pop_front();
			compares++;
			if (got !== want) begin
				miscompares++;
				$display("Error bus answer exp=%h got=%h", want, got);
			end
		end
	end
	initial begin
		#100000;
		miscompares++;
		final_report();
	end
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, mem, tmr, spi} = '0;
		{awaddr, araddr, wdata, a_ext, b_ext, xmem_addr_lo, xmem_wdata} = '0;
		{wstrb, a_ext_en} = 12'hFFF;
		r = $urandom(7);
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(port_mux_pkg::OFS_MCU_CONTROL, 16'h0000);
		rd(port_mux_pkg::OFS_PORT_B_DIR, 16'h0000);
		wr(port_mux_pkg::OFS_MCU_CONTROL, 8'hFF);
		rd(port_mux_pkg::OFS_MCU_CONTROL, 16'h0093);
		wr(8'h20, 8'h55, port_mux_pkg::RESP_SLVERR);
		wr(port_mux_pkg::OFS_PORT_B_PIN, 8'h55);
		wr(port_mux_pkg::OFS_MCU_CONTROL, 8'h00);
		for (int n = 0; n < 8; n++) begin
			r = $urandom;
			{da, oa, db, ob} = r;
			wr(port_mux_pkg::OFS_PORT_A_DIR, da);
			wr(port_mux_pkg::OFS_PORT_A_OUT, oa);
			wr(port_mux_pkg::OFS_PORT_B_DIR, db);
			wr(port_mux_pkg::OFS_PORT_B_OUT, ob);
			r = $urandom;
			{s, t} = r[30:16];
			{b_ext, a_ext} <= r[15:0];
			tmr <= t;
			spi <= s;
			repeat (4) @(posedge aclk);
			v = ob;
			if (t[9] | t[7]) v[7] = t[9] & t[8] | t[7] & t[6];
			if (t[5]) v[6] = t[4];
			if (t[3]) v[5] = t[2];
			if (t[1]) v[4] = t[0];
			dv = db;
			if (s[4] & s[3]) {dv[3], v[2], v[1]} = {1'b0, s[1], s[0]};
			if (s[4] & !s[3]) {dv[2:0], v[3]} = {3'h0, s[2]};
			pb = ~dv & ob;
			rd(port_mux_pkg::OFS_PORT_B_PIN, {8'h00, dv & v | ~dv & b_ext});
			rd(port_mux_pkg::OFS_PORT_A_PIN, {8'h00, da & oa | ~da & a_ext});
			rd(port_mux_pkg::OFS_PULLUP_STAT, {pb, ~da & oa});
		end
		wr(port_mux_pkg::OFS_PORT_A_DIR, 8'h00);
		wr(port_mux_pkg::OFS_PORT_A_OUT, 8'hFF);
		wr(port_mux_pkg::OFS_MCU_CONTROL, 8'h10);
		rd(port_mux_pkg::OFS_PULLUP_STAT, 16'h0000);
		wr(port_mux_pkg::OFS_MCU_CONTROL, 8'h00);
		for (int ph = 0; ph < 3; ph++) begin
			r = $urandom;
			mem <= {1'b1, ph == 1, ph == 2};
			{a_ext, xmem_wdata, xmem_addr_lo} <= r[23:0];
			a_ext_en <= ph == 0 ? 8'hFF : 8'h00;
			repeat (4) @(posedge aclk);
			v = ph == 0 ? r[23:16] : ph == 1 ? r[7:0] : r[15:8];
			rd(port_mux_pkg::OFS_PORT_A_PIN, {8'h00, v});
			rd(port_mux_pkg::OFS_PULLUP_STAT, {pb, ph == 0 ? 8'h00 : 8'hFF});
		end
		final_report();
	end
endmodule
